// >>> rtl/safe_direction_monitor.sv
// Safe direction monitor: direction decode, release sequence, mute, bypass and fault flags.
`timescale 1ns/1ps
`default_nettype none
module safe_direction_monitor
  import safe_direction_pkg::*;
#(
  parameter int MS_CYCLES = MS_TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             arst_n,
  // Encoder channels.
  input  wire logic             chanA,
  input  wire logic             chanB,
  // Operator and controller inputs.
  input  wire logic             restartIn,
  input  wire logic             muteIn,
  input  wire logic             bypassIn,
  input  wire logic             errorResetIn,
  input  wire logic             driveStopIn,
  // Configuration.
  input  wire logic             manualRestart,
  input  wire logic             useMute,
  input  wire logic             useBypass,
  input  wire logic             useTimeLimit,
  input  wire logic [SEC_W-1:0] timeLimitS,
  input  wire logic [1:0]       allowedDir,
  input  wire logic [MS_W-1:0]  toleranceMs,
  input  wire logic [1:0]       debounceSel,
  input  wire logic             useFlashing,
  input  wire logic             useFaultFlags,
  // Release and status.
  output logic                  releaseOut,
  output logic                  moveRight,
  output logic                  moveLeft,
  output logic                  noDirection,
  output logic                  restartRequired,
  output logic                  resetRequired,
  output logic                  vibFilterActive,
  // Fault flags.
  output logic                  flagNoDirection,
  output logic                  flagError,
  output logic                  flagCutoff,
  output logic                  flagStuck,
  output logic                  flagPhase,
  output logic                  flagDiscrepancy,
  output logic                  flagFreqDiff
);
  // Clamp a value into an inclusive range.
  function automatic logic [MS_W-1:0] clampMs(input logic [MS_W-1:0] v, input logic [MS_W-1:0] lo,
                                              input logic [MS_W-1:0] hi);
    clampMs = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // True when a running mute or bypass has used up its time limit.
  function automatic logic limitHit(input logic [SEC_W-1:0] sec, input logic [SEC_W-1:0] limit,
                                    input logic on);
    limitHit = on && (sec >= limit);
  endfunction

  logic [16:0]       msDiv_ff;
  logic              msTick_ff;
  logic [MS_W-1:0]   secMs_ff;
  logic              secTick;
  logic [1:0]        prevAB_ff;
  logic [7:0]        edgeGap_ff;
  logic              step;
  logic              stepRight;
  logic              phaseEvt;
  logic              cutoffEvt;
  logic              dirKnown_ff;
  logic              dirRight_ff;
  logic              errLatched_ff;
  logic              phaseLatched_ff;
  logic              cutoffLatched_ff;
  logic              resetPulse;
  logic              restartPulse;
  logic [MS_W-1:0]   wrongMs_ff;
  logic [MS_W-1:0]   tolMs;
  logic              wrongDir;
  logic              wrongExpired;
  logic              grant;
  logic [MS_W-1:0]   onMs_ff;
  release_state_e    state_ff;
  release_state_e    nxt_state;
  logic [SEC_W-1:0]  limitS;
  logic [SEC_W-1:0]  muteS_ff;
  logic [SEC_W-1:0]  bypassS_ff;
  logic              muteOn;
  logic              bypassOn;
  logic [MS_W-1:0]   flashMs_ff;
  logic              flashPhase_ff;
  logic              showReq;

  // Millisecond and second enables; one clock, no derived clocks.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      msDiv_ff  <= '0;
      msTick_ff <= 1'b0;
      secMs_ff  <= '0;
    end else begin
      msTick_ff <= (msDiv_ff == 17'(MS_CYCLES - 1));
      msDiv_ff  <= (msDiv_ff == 17'(MS_CYCLES - 1)) ? '0 : msDiv_ff + 1'b1;
      if (msTick_ff)
        secMs_ff <= (secMs_ff == MS_PER_S_W - 1'b1) ? '0 : secMs_ff + 1'b1;
    end
  end
  assign secTick = msTick_ff && (secMs_ff == MS_PER_S_W - 1'b1);

  // Quadrature decode: one channel change is a step, both at once is a phase fault.
  assign step      = (prevAB_ff != {chanA, chanB}) && !phaseEvt; // [R24]
  assign stepRight = prevAB_ff[1] ^ chanB;
  assign phaseEvt  = (prevAB_ff[1] != chanA) && (prevAB_ff[0] != chanB);
  assign cutoffEvt = step && (edgeGap_ff < 8'(MIN_EDGE_GAP));

  // Direction holds its last value at standstill; unknown only until the first step.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prevAB_ff   <= 2'h0;
      edgeGap_ff  <= 8'hFF;
      dirKnown_ff <= 1'b0;
      dirRight_ff <= 1'b0;
    end else begin
      prevAB_ff <= {chanA, chanB};
      if (step || phaseEvt)
        edgeGap_ff <= 8'h00;
      else if (edgeGap_ff != 8'hFF)
        edgeGap_ff <= edgeGap_ff + 1'b1;
      if (step) begin
        dirKnown_ff <= 1'b1; // [R13]
        dirRight_ff <= stepRight; // [R11]
      end
    end
  end

  // Error latch; a new fault in the clearing cycle wins over the operator's reset.
  // Under the vibration filter a phase fault is tolerated, a cut-off fault is not.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      errLatched_ff    <= 1'b0;
      phaseLatched_ff  <= 1'b0;
      cutoffLatched_ff <= 1'b0;
    end else begin
      if (resetPulse && errLatched_ff) begin
        errLatched_ff    <= 1'b0; // [R9] [R25]
        phaseLatched_ff  <= 1'b0;
        cutoffLatched_ff <= 1'b0;
      end
      if ((phaseEvt && !driveStopIn) || cutoffEvt) // [R14]
        errLatched_ff <= 1'b1; // [R8]
      if (phaseEvt && !driveStopIn)
        phaseLatched_ff <= 1'b1;
      if (cutoffEvt)
        cutoffLatched_ff <= 1'b1;
    end
  end

  // Debounced operator pulses.
  pulse_debounce u_reset_deb (
    .clock       (clock),
    .arst_n      (arst_n),
    .msTick      (msTick_ff),
    .debounceSel (debounceSel),
    .level       (errorResetIn),
    .pulse_ff    (resetPulse)
  );
  pulse_debounce u_restart_deb (
    .clock       (clock),
    .arst_n      (arst_n),
    .msTick      (msTick_ff),
    .debounceSel (debounceSel),
    .level       (restartIn),
    .pulse_ff    (restartPulse)
  );

  // Wrong-direction tolerance, clamped into its permitted range.
  assign tolMs        = clampMs(toleranceMs, TOLERANCE_MIN_MS, TOLERANCE_MAX_MS);
  assign wrongDir     = dirKnown_ff && (dirRight_ff != (allowedDir != DIR_LEFT)); // [R17]
  assign wrongExpired = wrongDir && (wrongMs_ff >= tolMs); // [R18]
  assign grant        = !errLatched_ff && !wrongExpired; // [R22] [R23]

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      wrongMs_ff <= '0;
    else if (!wrongDir)
      wrongMs_ff <= '0;
    else if (msTick_ff && wrongMs_ff != TOLERANCE_MAX_MS)
      wrongMs_ff <= wrongMs_ff + 1'b1; // [R18]
  end

  // Release sequence: switch-on delay, then manual acknowledge or automatic release.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_BLOCKED:  if (grant) nxt_state = ST_DELAY;
      ST_DELAY: begin
        if (!grant)
          nxt_state = ST_BLOCKED;
        else if (onMs_ff >= SWITCH_ON_DELAY_MS) // [R1]
          nxt_state = manualRestart ? ST_PENDING : ST_RELEASED; // [R16]
      end
      ST_PENDING: begin
        if (!grant)
          nxt_state = ST_BLOCKED;
        else if (restartPulse)
          nxt_state = ST_RELEASED; // [R2]
      end
      ST_RELEASED: if (!grant) nxt_state = ST_BLOCKED; // [R22]
      default:     nxt_state = ST_BLOCKED;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_BLOCKED;
      onMs_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff != ST_DELAY)
        onMs_ff <= '0;
      else if (msTick_ff && onMs_ff != TOLERANCE_MAX_MS)
        onMs_ff <= onMs_ff + 1'b1; // [R1]
    end
  end

  // Mute and bypass with optional time limit; the timer restarts when the input drops.
  assign limitS   = TIME_LIMIT_MIN_S > timeLimitS ? TIME_LIMIT_MIN_S :
                    (timeLimitS > TIME_LIMIT_MAX_S ? TIME_LIMIT_MAX_S : timeLimitS);
  assign muteOn   = useMute && muteIn && !limitHit(muteS_ff, limitS, useTimeLimit); // [R5] [R7]
  assign bypassOn = useBypass && bypassIn && !limitHit(bypassS_ff, limitS, useTimeLimit); // [R6] [R7]

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      muteS_ff   <= '0;
      bypassS_ff <= '0;
    end else begin
      if (!muteIn)
        muteS_ff <= '0;
      else if (secTick && muteS_ff != TIME_LIMIT_MAX_S)
        muteS_ff <= muteS_ff + 1'b1; // [R7]
      if (!bypassIn)
        bypassS_ff <= '0;
      else if (secTick && bypassS_ff != TIME_LIMIT_MAX_S)
        bypassS_ff <= bypassS_ff + 1'b1; // [R7]
    end
  end

  // Flash divider for the two required outputs.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flashMs_ff    <= '0;
      flashPhase_ff <= 1'b1;
    end else if (msTick_ff) begin
      flashMs_ff <= (flashMs_ff == FLASH_HALF_MS - 1'b1) ? '0 : flashMs_ff + 1'b1;
      if (flashMs_ff == FLASH_HALF_MS - 1'b1)
        flashPhase_ff <= !flashPhase_ff;
    end
  end
  assign showReq = !useFlashing || flashPhase_ff; // [R20]

  // Registered outputs. Mute only holds a release that is already high.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      releaseOut      <= 1'b0;
      moveRight       <= 1'b0;
      moveLeft        <= 1'b0;
      noDirection     <= 1'b1;
      restartRequired <= 1'b0;
      resetRequired   <= 1'b0;
      vibFilterActive <= 1'b0;
    end else begin
      releaseOut      <= (state_ff == ST_RELEASED) || bypassOn || (muteOn && releaseOut); // [R3] [R4]
      moveRight       <= dirKnown_ff && dirRight_ff; // [R11]
      moveLeft        <= dirKnown_ff && !dirRight_ff; // [R11]
      noDirection     <= !dirKnown_ff; // [R13]
      restartRequired <= (state_ff == ST_PENDING) && showReq; // [R12]
      resetRequired   <= errLatched_ff && showReq; // [R8]
      vibFilterActive <= driveStopIn; // [R10] [R14]
    end
  end

  // Fault flags; stuck, discrepancy and frequency difference need a second sensor and stay low.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flagNoDirection <= 1'b0;
      flagError       <= 1'b0;
      flagCutoff      <= 1'b0;
      flagStuck       <= 1'b0;
      flagPhase       <= 1'b0;
      flagDiscrepancy <= 1'b0;
      flagFreqDiff    <= 1'b0;
    end else begin
      flagNoDirection <= useFaultFlags && !dirKnown_ff; // [R15]
      flagError       <= useFaultFlags && errLatched_ff; // [R15]
      flagCutoff      <= useFaultFlags && cutoffLatched_ff; // [R15]
      flagStuck       <= 1'b0;
      flagPhase       <= useFaultFlags && phaseLatched_ff; // [R15]
      flagDiscrepancy <= 1'b0;
      flagFreqDiff    <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_switch_on_delay: assert property ($rose(state_ff == ST_RELEASED) |-> // [R1]
    $past(onMs_ff >= SWITCH_ON_DELAY_MS || restartPulse)) else $error("Release without switch-on delay.");
  a_manual_ack: assert property (manualRestart && $changed(manualRestart) == 1'b0 && // [R2]
    $rose(state_ff == ST_RELEASED) |-> $past(restartPulse)) else $error("Manual release without restart.");
  a_mute_holds: assert property (muteOn && releaseOut |=> releaseOut) // [R3]
    else $error("Mute failed to hold release.");
  a_bypass_forces: assert property (bypassOn |=> releaseOut) // [R4]
    else $error("Bypass failed to force release.");
  // The gating checks look at the release pin itself, so a bad mux in the output path is caught too.
  a_mute_gated: assert property (!useMute && !bypassOn && state_ff != ST_RELEASED |=> !releaseOut) // [R5]
    else $error("Mute active while not in use.");
  a_bypass_gated: assert property (!useBypass && !(muteOn && releaseOut) && state_ff != ST_RELEASED |=> // [R6]
    !releaseOut) else $error("Bypass active while not in use.");
  a_limit_ends: assert property (useTimeLimit && muteS_ff >= limitS && !bypassOn && state_ff != ST_RELEASED |=> // [R7]
    !releaseOut) else $error("Mute outlived its time limit.");
  // Bypass or mute arriving in the cycle after the fault may still hold the pin, so both are excluded there too.
  a_wrong_dir_drop: assert property (wrongExpired && !bypassOn && !muteOn ##1 // [R22]
    !bypassOn && !muteOn |=> !releaseOut) else $error("Release kept after wrong direction.");
  a_dir_exclusive: assert property (!(moveRight && moveLeft) && !(noDirection && (moveRight || moveLeft))) // [R11]
    else $error("Direction outputs overlap.");
  a_reset_clears: assert property (resetPulse && errLatched_ff && !phaseEvt && !cutoffEvt |=> // [R25]
    !errLatched_ff ##1 !resetRequired) else $error("Error reset not accepted.");
  a_restart_req: assert property (state_ff == ST_PENDING && !useFlashing |=> restartRequired) // [R12]
    else $error("Restart required not shown.");

  c_release: cover property ($rose(releaseOut));
  c_manual_release: cover property (state_ff == ST_PENDING ##1 state_ff == ST_RELEASED);
  c_bypass: cover property (bypassOn && state_ff != ST_RELEASED);
  c_error_reset: cover property (errLatched_ff ##1 !errLatched_ff);
endmodule
`default_nettype wire

// >>> rtl/safe_direction_pkg.sv
// Constants, encodings and timing for the safe direction release monitor.
// Operation
// [R1] Release rises only after 500 ms grant.
// [R2] Manual mode needs low-high-low restart pulse.
// [R3] Mute holds an already active release.
// [R4] Bypass forces the release output high.
// [R5] Mute works only when mute-use is on.
// [R6] Bypass works only when bypass-use is on.
// [R7] Time limit ends mute or bypass, 1-7200 s.
// [R8] Latched error raises reset-required; operator confirms.
// [R9] Error reset resumes release evaluation.
// [R10] Controller drives drive-stop high at standstill.
// [R11] Right and left movement outputs show direction.
// [R12] Restart-required shows release awaiting manual acknowledge.
// [R13] No-direction output until direction is known.
// [R14] Vibration filter active output; phase errors tolerated.
// [R15] Fault flag outputs only when enabled.
// [R16] Restart mode selects manual or automatic.
// [R17] Allowed direction: 1 right, 2 left.
// [R18] Wrong direction tolerated for 4-10000 ms.
// [R19] Reset and restart pulses need debounce time.
// [R20] Required outputs may flash instead of steady.
// [R21] Sensor must supply direction information.
// [R22] Wrong direction beyond tolerance clears release.
// [R23] Release granted from standstill with unknown direction.
// [R24] Sensor delivers phase-shifted channels A and B.
// [R25] Accepted error reset clears reset-required.
package safe_direction_pkg;
  // Clock and millisecond base.
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MS_PERIOD_NS   = 1000000;
  localparam int MS_TICK_CYCLES = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_PER_S       = 1000;
  // Widths of the millisecond and second counters.
  localparam int MS_W  = 14;
  localparam int SEC_W = 13;
  // Timing figures in milliseconds or seconds.
  localparam logic [MS_W-1:0]  SWITCH_ON_DELAY_MS = 14'h01F4;
  localparam logic [MS_W-1:0]  TOLERANCE_MIN_MS   = 14'h0004;
  localparam logic [MS_W-1:0]  TOLERANCE_MAX_MS   = 14'h2710;
  localparam logic [SEC_W-1:0] TIME_LIMIT_MIN_S   = 13'h0001;
  localparam logic [SEC_W-1:0] TIME_LIMIT_MAX_S   = 13'h1C20;
  localparam logic [MS_W-1:0]  DEBOUNCE_100_MS    = 14'h0064;
  localparam logic [MS_W-1:0]  DEBOUNCE_350_MS    = 14'h015E;
  localparam logic [MS_W-1:0]  FLASH_HALF_MS      = 14'h00FA;
  localparam logic [MS_W-1:0]  MS_PER_S_W         = 14'h03E8;
  // Debounce selection codes.
  localparam logic [1:0] DEB_SEL_CYCLE = 2'h0;
  localparam logic [1:0] DEB_SEL_100   = 2'h1;
  localparam logic [1:0] DEB_SEL_350   = 2'h2;
  // Allowed direction codes.
  localparam logic [1:0] DIR_RIGHT = 2'h1;
  localparam logic [1:0] DIR_LEFT  = 2'h2;
  // Least spacing of encoder edges before a cut-off fault, in cycles.
  localparam int MIN_EDGE_GAP = 4;
  // Release sequence, Gray coded along blocked, delay, pending, released.
  typedef enum logic [1:0] {
    ST_BLOCKED  = 2'h0,
    ST_DELAY    = 2'h1,
    ST_PENDING  = 2'h3,
    ST_RELEASED = 2'h2
  } release_state_e;
endpackage

// >>> rtl/pulse_debounce.sv
// Debounced low-high-low pulse detector for the reset and restart inputs.
`timescale 1ns/1ps
`default_nettype none
module pulse_debounce
  import safe_direction_pkg::*;
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       arst_n,
  // Timing.
  input  wire logic       msTick,
  input  wire logic [1:0] debounceSel,
  // Operator input and accepted pulse.
  input  wire logic       level,
  output logic            pulse_ff
);
  logic            prev_ff;
  logic [MS_W-1:0] highMs_ff;
  logic [MS_W-1:0] needMs;

  // A code of 3 is treated as the default 100 ms.
  always_comb begin
    case (debounceSel)
      DEB_SEL_CYCLE: needMs = '0;
      DEB_SEL_350:   needMs = DEBOUNCE_350_MS;
      default:       needMs = DEBOUNCE_100_MS;
    endcase
  end

  // Count whole milliseconds of the high phase, saturating well above 350.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_ff   <= 1'b0;
      highMs_ff <= '0;
    end else begin
      prev_ff <= level;
      if (!level)
        highMs_ff <= '0;
      else if (msTick && highMs_ff != TOLERANCE_MAX_MS)
        highMs_ff <= highMs_ff + 1'b1;
    end
  end

  // The pulse counts at its falling edge; a tick count above the need rounds up the least time.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      pulse_ff <= 1'b0;
    else
      pulse_ff <= prev_ff && !level && (debounceSel == DEB_SEL_CYCLE || highMs_ff > needMs); // [R19]
  end

  a_pulse_on_fall: assert property (@(posedge clock) disable iff (!arst_n) // [R19]
    pulse_ff |-> $past(prev_ff && !level)) else $error("Debounced pulse without falling edge.");
endmodule
`default_nettype wire

// >>> tb/encoder_model.sv
// Behavioural quadrature encoder with direction information for the monitor's channel inputs.
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
  // Clock.
  input  wire logic       clock,
  // Step command: 0 hold, 1 right, 2 left, 3 both channels at once.
  input  wire logic [1:0] stepCmd,
  // Channel outputs.
  output logic            chanA,
  output logic            chanB
);
  logic [1:0] phase;

  initial phase = 2'h0;

  // Phase walks the Gray cycle, so one channel changes per step and direction stays readable.
  // Code 3 moves two places and flips both channels, which is the fault case.
  always @(posedge clock) begin
    case (stepCmd)
      2'h1: phase <= phase + 2'h1;
      2'h2: phase <= phase - 2'h1;
      2'h3: phase <= phase + 2'h2;
      default: phase <= phase;
    endcase
  end

  // Right order on AB is 00, 01, 11, 10.
  assign chanA = phase[1];
  assign chanB = phase[1] ^ phase[0];
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench for the safe direction monitor and its encoder model.
`timescale 1ns/1ps
`default_nettype none
module tb
  import safe_direction_pkg::*;
;
  // Millisecond tick shortened so the 500 ms delay stays short in cycles.
  localparam int MS = 10;

  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] stepCmd = 2'h0;
  logic chanA, chanB;
  logic restartIn = 1'b0, muteIn = 1'b0, bypassIn = 1'b0, errorResetIn = 1'b0, driveStopIn = 1'b0;
  logic manualRestart = 1'b0, useMute = 1'b0, useBypass = 1'b0, useTimeLimit = 1'b1;
  logic [SEC_W-1:0] timeLimitS = 13'h0001;
  logic [1:0] allowedDir = 2'h1;
  logic [MS_W-1:0] toleranceMs = 14'h0004;
  logic [1:0] debounceSel = 2'h1;
  logic useFlashing = 1'b0, useFaultFlags = 1'b0;
  logic releaseOut, moveRight, moveLeft, noDirection, restartRequired, resetRequired, vibFilterActive;
  logic flagNoDirection, flagError, flagCutoff, flagStuck, flagPhase, flagDiscrepancy, flagFreqDiff;
  int failCount = 0;
  int checked = 0;

  always #5 clock = ~clock;

  encoder_model i_enc (.clock(clock), .stepCmd(stepCmd), .chanA(chanA), .chanB(chanB));

  safe_direction_monitor #(.MS_CYCLES(MS)) i_dut (
    .clock(clock), .arst_n(arst_n), .chanA(chanA), .chanB(chanB),
    .restartIn(restartIn), .muteIn(muteIn), .bypassIn(bypassIn), .errorResetIn(errorResetIn),
    .driveStopIn(driveStopIn), .manualRestart(manualRestart), .useMute(useMute), .useBypass(useBypass),
    .useTimeLimit(useTimeLimit), .timeLimitS(timeLimitS), .allowedDir(allowedDir),
    .toleranceMs(toleranceMs), .debounceSel(debounceSel), .useFlashing(useFlashing),
    .useFaultFlags(useFaultFlags), .releaseOut(releaseOut), .moveRight(moveRight), .moveLeft(moveLeft),
    .noDirection(noDirection), .restartRequired(restartRequired), .resetRequired(resetRequired),
    .vibFilterActive(vibFilterActive), .flagNoDirection(flagNoDirection), .flagError(flagError),
    .flagCutoff(flagCutoff), .flagStuck(flagStuck), .flagPhase(flagPhase),
    .flagDiscrepancy(flagDiscrepancy), .flagFreqDiff(flagFreqDiff)
  );

  // Compare one value; seen is copied when the task is called, so the small delay comes after sampling.
  task automatic check(input logic seen, input logic exp);
    #1;
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %0t: got %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic waitMs(input int n);
    repeat (n * MS) @(posedge clock);
  endtask

  // One encoder step, spaced eight cycles so no cut-off fault is provoked.
  task automatic step(input logic [1:0] cmd);
    @(posedge clock) stepCmd <= cmd;
    @(posedge clock) stepCmd <= 2'h0;
    repeat (6) @(posedge clock);
  endtask

  // Low-high-low pulse on restart (which=1) or error reset (which=0), high for ms milliseconds.
  task automatic opPulse(input bit which, input int ms);
    @(posedge clock);
    if (which) restartIn <= 1'b1;
    else errorResetIn <= 1'b1;
    waitMs(ms);
    @(posedge clock);
    restartIn <= 1'b0;
    errorResetIn <= 1'b0;
    repeat (5) @(posedge clock);
  endtask

  task automatic testReset();
    check(noDirection, 1'b1);
    check(releaseOut, 1'b0);
    check(resetRequired, 1'b0);
    check(flagPhase, 1'b0);
    @(posedge clock) useFaultFlags <= 1'b1;
    repeat (2) @(posedge clock);
    check(flagNoDirection, 1'b1);
    @(posedge clock) useFaultFlags <= 1'b0;
    $display("reset test done");
  endtask

  // Release from standstill waits the switch-on delay.
  task automatic testRelease();
    step(2'h1);
    step(2'h1);
    check(moveRight, 1'b1);
    check(moveLeft, 1'b0);
    check(noDirection, 1'b0);
    waitMs(488);
    check(releaseOut, 1'b0);
    waitMs(14);
    check(releaseOut, 1'b1);
    $display("release test done");
  endtask

  // A short reversal is tolerated, a held one drops the release.
  task automatic testTolerance();
    step(2'h2);
    step(2'h1);
    check(releaseOut, 1'b1);
    step(2'h2);
    waitMs(8);
    check(releaseOut, 1'b0);
    check(moveLeft, 1'b1);
    step(2'h1);
    $display("tolerance test done");
  endtask

  // Phase fault, a refused short reset, then an accepted one.
  task automatic testError();
    step(2'h3);
    check(resetRequired, 1'b1);
    check(flagPhase, 1'b0);
    check(releaseOut, 1'b0);
    opPulse(1'b0, 50);
    check(resetRequired, 1'b1);
    opPulse(1'b0, 105);
    check(resetRequired, 1'b0);
    waitMs(503);
    check(releaseOut, 1'b1);
    $display("error test done");
  endtask

  // Fault flags, flashing, then a manual restart handshake.
  task automatic testManual();
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    @(posedge clock);
    manualRestart <= 1'b1;
    useFaultFlags <= 1'b1;
    useFlashing <= 1'b1;
    step(2'h3);
    check(flagPhase, 1'b1);
    check(flagError, 1'b1);
    // Two encoder steps one cycle apart provoke the cut-off fault.
    @(posedge clock) stepCmd <= 2'h1;
    repeat (2) @(posedge clock);
    stepCmd <= 2'h0;
    repeat (4) @(posedge clock);
    check(flagCutoff, 1'b1);
    check(flagStuck | flagDiscrepancy | flagFreqDiff | flagNoDirection, 1'b0);
    repeat (600 * MS) begin
      @(negedge clock);
      if (resetRequired === 1'b1) hi++;
      if (resetRequired === 1'b0) lo++;
    end
    check(hi > 0, 1'b1);
    check(lo > 0, 1'b1);
    @(posedge clock);
    useFlashing <= 1'b0;
    debounceSel <= 2'h0;
    opPulse(1'b0, 1);
    check(resetRequired, 1'b0);
    @(posedge clock) debounceSel <= 2'h1;
    waitMs(505);
    check(restartRequired, 1'b1);
    check(releaseOut, 1'b0);
    opPulse(1'b1, 105);
    check(releaseOut, 1'b1);
    check(restartRequired, 1'b0);
    @(posedge clock) manualRestart <= 1'b0;
    $display("manual test done");
  endtask

  // With drive stop high a phase fault keeps the release.
  task automatic testVibration();
    @(posedge clock) driveStopIn <= 1'b1;
    repeat (3) @(posedge clock);
    check(vibFilterActive, 1'b1);
    step(2'h3);
    check(releaseOut, 1'b1);
    check(resetRequired, 1'b0);
    @(posedge clock) driveStopIn <= 1'b0;
    repeat (2) @(posedge clock);
    check(vibFilterActive, 1'b0);
    $display("vibration test done");
  endtask

  // Mute holds until its limit; bypass forces only when enabled.
  task automatic testMuteBypass();
    @(posedge clock);
    useMute <= 1'b1;
    muteIn <= 1'b1;
    step(2'h2);
    waitMs(10);
    check(releaseOut, 1'b1);
    waitMs(2100);
    check(releaseOut, 1'b0);
    @(posedge clock);
    muteIn <= 1'b0;
    useMute <= 1'b0;
    bypassIn <= 1'b1;
    repeat (3) @(posedge clock);
    check(releaseOut, 1'b0);
    @(posedge clock) useBypass <= 1'b1;
    repeat (3) @(posedge clock);
    check(releaseOut, 1'b1);
    @(posedge clock) bypassIn <= 1'b0;
    repeat (3) @(posedge clock);
    check(releaseOut, 1'b0);
    $display("mute and bypass test done");
  endtask

  // Moving left, the left setting grants the release again.
  task automatic testLeft();
    @(posedge clock) allowedDir <= 2'h2;
    waitMs(505);
    check(releaseOut, 1'b1);
    check(moveLeft, 1'b1);
    $display("left direction test done");
  endtask

  // Watchdog sized above the roughly 50,000 cycles the tests take.
  initial begin
    repeat (70000) @(posedge clock);
    failCount++;
    printVerdict();
  end

  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    testReset();
    testRelease();
    testTolerance();
    testError();
    testManual();
    testVibration();
    testMuteBypass();
    testLeft();
    printVerdict();
  end
endmodule
`default_nettype wire
